/* File: design/ppi_port.sv */
`include "ppi_defines.svh"
`default_nettype none
// Notes on behaviour
// - Four byte registers: control plus data for ports A, B and C.
// - Data reads return line state, or the strobe-latched byte for inputs in modes 1 and 2; data writes set output lines.
// - Mode 0: ports A, B, C halves simple; outputs latched, inputs live.
// - Mode 1: A+C low and B+C high groups; data latched both ways.
// - Mode 2: A with C3..5, B with C0..2 handshakes; data latched.
// - Control word: set, mode pair, A, upper C, B mode, B, lower C.
// - Control word applies only when its top bit is set.
// - Mode pair 00, 01, 1X picks mode 0, 1, 2; B mode bit forces 1 unless the pair is 1X.
// - Direction bit 1 makes group input, 0 makes it output.
// - Reset gives mode 0 with every port an input, nothing driven.
// - Port A lowest address, then B, C, control at highest.
module ppi_port (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] addr,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata_q,
	input  wire logic [7:0] port_a_in,
	output var  logic [7:0] port_a_out_q,
	output var  logic       port_a_oe_q,
	input  wire logic [7:0] port_b_in,
	output var  logic [7:0] port_b_out_q,
	output var  logic       port_b_oe_q,
	input  wire logic [7:0] port_c_in,
	output var  logic [7:0] port_c_out_q,
	output var  logic [7:0] port_c_oe_q
);
	// ------------------------------------------------------------------
	// Host access decode
	// ------------------------------------------------------------------
	// The bus is sampled each clock; a held strobe is a single access,
	// so only the first cycle of a strobe acts.
	// The strobe history starts out idle, so that an access already
	// standing at the first edge after reset is still taken.
	logic rd_prev_q;
	logic wr_prev_q;
	logic rd_evt;
	logic wr_evt;

	assign rd_evt = !cs_n && !rd_n && rd_prev_q;
	assign wr_evt = !cs_n && !wr_n && wr_prev_q;

	function automatic logic hit(input logic [1:0] a, input logic [1:0] r);
		return a == r;
	endfunction

	// Both groups share port C, so either group asking for mode 1 puts
	// the whole port into mode 1 unless group A asks for mode 2; a split of mode 0 and 1 is not served.
	function automatic ppi_pkg::ppi_mode_t decode_mode(input logic [7:0] w);
		if (w[`PPI_BIT_MODE_HI]) begin
			return ppi_pkg::MODE_2;
		end else if (w[`PPI_BIT_MODE_LO] || w[`PPI_BIT_GRPB_MODE]) begin
			return ppi_pkg::MODE_1;
		end
		return ppi_pkg::MODE_0;
	endfunction

	// ------------------------------------------------------------------
	// Configuration and output latches
	// ------------------------------------------------------------------
	logic [7:0]         parallel_io_control_q;
	logic [7:0]         parallel_io_control_d;
	logic [7:0]         a_latch_q;
	logic [7:0]         a_latch_d;
	logic [7:0]         b_latch_q;
	logic [7:0]         b_latch_d;
	logic [7:0]         c_latch_q;
	logic [7:0]         c_latch_d;
	ppi_pkg::ppi_mode_t mode;
	logic               dir_a_in;
	logic               dir_b_in;
	logic               dir_c_up_in;
	logic               dir_c_low_in;
	logic               hs_mode;

	assign mode         = decode_mode(parallel_io_control_q);
	assign hs_mode      = mode != ppi_pkg::MODE_0;
	assign dir_a_in     = parallel_io_control_q[`PPI_BIT_DIR_A];
	assign dir_b_in     = parallel_io_control_q[`PPI_BIT_DIR_B];
	assign dir_c_up_in  = parallel_io_control_q[`PPI_BIT_DIR_C_UP];
	assign dir_c_low_in = parallel_io_control_q[`PPI_BIT_DIR_C_LOW];

	// ------------------------------------------------------------------
	// Handshake pin placement
	// ------------------------------------------------------------------
	// Pins that swap between data and handshake duty on a mode change
	// may show one stale cycle; reprogram while the far side is idle.
	// Handshake pins on port C. Mode 1: A uses C0..2, B uses C4..6.
	// Mode 2: A uses C3..5, B uses C0..2. Within each group the lowest
	// pin is the strobe or acknowledge input, the next the full output,
	// the next the request output.
	logic [2:0] a_hs_pos;
	logic [2:0] b_hs_pos;
	assign a_hs_pos = (mode == ppi_pkg::MODE_2) ? 3'h3 : 3'h0;
	assign b_hs_pos = (mode == ppi_pkg::MODE_2) ? 3'h0 : 3'h4;

	logic a_strb_n;
	logic b_strb_n;
	assign a_strb_n = port_c_in[a_hs_pos];
	assign b_strb_n = port_c_in[b_hs_pos];

	always_comb begin
		parallel_io_control_d = parallel_io_control_q;
		a_latch_d = a_latch_q;
		b_latch_d = b_latch_q;
		c_latch_d = c_latch_q;
		if (wr_evt) begin
			unique case (addr)
				`PPI_ADDR_PORT_A: a_latch_d = wdata;
				`PPI_ADDR_PORT_B: b_latch_d = wdata;
				`PPI_ADDR_PORT_C: c_latch_d = wdata;
				`PPI_ADDR_CONTROL: begin
					// A word without the set flag changes nothing. A
					// new mode clears the output latches, so a port
					// turned to output starts low, not with a stale byte.
					if (wdata[`PPI_BIT_SET_FLAG]) begin
						parallel_io_control_d = wdata;
						a_latch_d = `PPI_DATA_RESET;
						b_latch_d = `PPI_DATA_RESET;
						c_latch_d = `PPI_DATA_RESET;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Strobed input latches and output-side buffer full flags
	// ------------------------------------------------------------------
	logic [7:0] a_held_q;
	logic [7:0] b_held_q;
	logic       a_ibf_q;
	logic       b_ibf_q;
	logic       rd_a;
	logic       rd_b;
	logic       wr_a;
	logic       wr_b;
	logic       a_obf_q;
	logic       a_obf_d;
	logic       b_obf_q;
	logic       b_obf_d;
	logic       a_ack_prev_q;
	logic       b_ack_prev_q;

	assign rd_a = rd_evt && hit(addr, `PPI_ADDR_PORT_A);
	assign rd_b = rd_evt && hit(addr, `PPI_ADDR_PORT_B);
	assign wr_a = wr_evt && hit(addr, `PPI_ADDR_PORT_A);
	assign wr_b = wr_evt && hit(addr, `PPI_ADDR_PORT_B);

	// Strobes are seen through a flop, so a strobe pulse must stand low
	// across at least one rising clock edge or it is lost.
	ppi_strobe_latch #(.WIDTH(8)) a_latch_in (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.enable    (hs_mode && dir_a_in),
		.strobe_n  (a_strb_n),
		.pins      (port_a_in),
		.host_read (rd_a),
		.latched_q (a_held_q),
		.full_q    (a_ibf_q)
	);

	ppi_strobe_latch #(.WIDTH(8)) b_latch_in (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.enable    (hs_mode && dir_b_in),
		.strobe_n  (b_strb_n),
		.pins      (port_b_in),
		.host_read (rd_b),
		.latched_q (b_held_q),
		.full_q    (b_ibf_q)
	);

	// Output full goes low on acknowledge; a write in the same cycle wins,
	// because losing the write would strand a byte that the far side
	// would never be told about.
	always_comb begin
		a_obf_d = a_obf_q;
		b_obf_d = b_obf_q;
		if (!hs_mode || dir_a_in) begin
			a_obf_d = 1'b0;
		end else begin
			if (a_ack_prev_q && !a_strb_n) a_obf_d = 1'b0;
			if (wr_a) a_obf_d = 1'b1;
		end
		if (!hs_mode || dir_b_in) begin
			b_obf_d = 1'b0;
		end else begin
			if (b_ack_prev_q && !b_strb_n) b_obf_d = 1'b0;
			if (wr_b) b_obf_d = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Pin drive and read data
	// ------------------------------------------------------------------
	logic [7:0] a_out_d;
	logic       a_oe_d;
	logic [7:0] b_out_d;
	logic       b_oe_d;
	logic [7:0] c_out_d;
	logic [7:0] c_oe_d;
	logic [7:0] rdata_d;
	logic [7:0] c_read;
	logic       a_flag;
	logic       b_flag;
	logic       a_req;
	logic       b_req;

	assign a_flag = dir_a_in ? a_ibf_q : a_obf_q;
	assign b_flag = dir_b_in ? b_ibf_q : b_obf_q;
	assign a_req  = dir_a_in ? a_ibf_q : !a_obf_q;
	assign b_req  = dir_b_in ? b_ibf_q : !b_obf_q;

	always_comb begin
		a_out_d = a_latch_q;
		b_out_d = b_latch_q;
		a_oe_d  = !dir_a_in;
		b_oe_d  = !dir_b_in;
		c_out_d = c_latch_q;
		c_oe_d  = {{4{!dir_c_up_in}}, {4{!dir_c_low_in}}};
		c_read  = port_c_in;
		if (hs_mode) begin
			// The strobe pin is an input; full and request are driven.
			// Flags read back as driven, not from the pins, so a load on
			// the line cannot hide the device's own state from the host.
			c_oe_d[a_hs_pos]                    = 1'b0;
			c_oe_d[a_hs_pos + 3'h1]             = 1'b1;
			c_oe_d[a_hs_pos + 3'h2]             = 1'b1;
			c_out_d[a_hs_pos + 3'h1]            = a_flag;
			c_out_d[a_hs_pos + 3'h2]            = a_req;
			c_oe_d[b_hs_pos]                    = 1'b0;
			c_oe_d[b_hs_pos + 3'h1]             = 1'b1;
			c_oe_d[b_hs_pos + 3'h2]             = 1'b1;
			c_out_d[b_hs_pos + 3'h1]            = b_flag;
			c_out_d[b_hs_pos + 3'h2]            = b_req;
			c_read[a_hs_pos + 3'h1]             = a_flag;
			c_read[a_hs_pos + 3'h2]             = a_req;
			c_read[b_hs_pos + 3'h1]             = b_flag;
			c_read[b_hs_pos + 3'h2]             = b_req;
		end
		rdata_d = rdata_q;
		if (rd_evt) begin
			unique case (addr)
				`PPI_ADDR_PORT_A: rdata_d = (hs_mode && dir_a_in) ? a_held_q
					: (dir_a_in ? port_a_in : a_latch_q);
				`PPI_ADDR_PORT_B: rdata_d = (hs_mode && dir_b_in) ? b_held_q
					: (dir_b_in ? port_b_in : b_latch_q);
				`PPI_ADDR_PORT_C: rdata_d = c_read;
				`PPI_ADDR_CONTROL: rdata_d = parallel_io_control_q;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_prev_q    <= 1'b1;
			wr_prev_q    <= 1'b1;
			parallel_io_control_q <= `PPI_CONTROL_RESET;
			a_latch_q    <= `PPI_DATA_RESET;
			b_latch_q    <= `PPI_DATA_RESET;
			c_latch_q    <= `PPI_DATA_RESET;
			a_obf_q      <= 1'b0;
			b_obf_q      <= 1'b0;
			a_ack_prev_q <= 1'b1;
			b_ack_prev_q <= 1'b1;
			port_a_out_q <= `PPI_DATA_RESET;
			port_a_oe_q  <= 1'b0;
			port_b_out_q <= `PPI_DATA_RESET;
			port_b_oe_q  <= 1'b0;
			port_c_out_q <= `PPI_DATA_RESET;
			port_c_oe_q  <= 8'h00;
			rdata_q      <= 8'h00;
		end else begin
			rd_prev_q    <= cs_n || rd_n;
			wr_prev_q    <= cs_n || wr_n;
			parallel_io_control_q <= parallel_io_control_d;
			a_latch_q    <= a_latch_d;
			b_latch_q    <= b_latch_d;
			c_latch_q    <= c_latch_d;
			a_obf_q      <= a_obf_d;
			b_obf_q      <= b_obf_d;
			a_ack_prev_q <= a_strb_n;
			b_ack_prev_q <= b_strb_n;
			port_a_out_q <= a_out_d;
			port_a_oe_q  <= a_oe_d;
			port_b_out_q <= b_out_d;
			port_b_oe_q  <= b_oe_d;
			port_c_out_q <= c_out_d;
			port_c_oe_q  <= c_oe_d;
			rdata_q      <= rdata_d;
		end
	end
endmodule // ppi_port
`default_nettype wire

/* File: design/ppi_defines.svh */
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH
// ----------------------------------------------------------------------
// Register addresses and control word layout
// ----------------------------------------------------------------------
`define PPI_ADDR_PORT_A   2'h0
`define PPI_ADDR_PORT_B   2'h1
`define PPI_ADDR_PORT_C   2'h2
`define PPI_ADDR_CONTROL  2'h3
`define PPI_BIT_SET_FLAG  7
`define PPI_BIT_MODE_HI   6
`define PPI_BIT_MODE_LO   5
`define PPI_BIT_DIR_A     4
`define PPI_BIT_DIR_C_UP  3
`define PPI_BIT_GRPB_MODE 2
`define PPI_BIT_DIR_B     1
`define PPI_BIT_DIR_C_LOW 0
`define PPI_CONTROL_RESET 8'h9B
`define PPI_DATA_RESET    8'h00
`endif

/* File: design/ppi_pkg.sv */
`default_nettype none
package ppi_pkg;
	typedef enum logic [1:0] {
		MODE_0,
		MODE_1,
		MODE_2
	} ppi_mode_t;
endpackage
`default_nettype wire

/* File: design/ppi_strobe_latch.sv */
`default_nettype none
// ----------------------------------------------------------------------
// Strobed input latch for handshaked modes
// ----------------------------------------------------------------------
// Latches pins on a falling strobe and reports buffer full until the
// host reads the latched value.
module ppi_strobe_latch #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             enable,
	input  wire logic             strobe_n,
	input  wire logic [WIDTH-1:0] pins,
	input  wire logic             host_read,
	output var  logic [WIDTH-1:0] latched_q,
	output var  logic             full_q
);
	if (WIDTH < 1) begin : g_width_check
		$error("WIDTH must be positive");
	end

	logic             strobe_prev_q;
	logic             strobe_prev_d;
	logic [WIDTH-1:0] latched_d;
	logic             full_d;

	always_comb begin
		strobe_prev_d = strobe_n;
		latched_d     = latched_q;
		full_d        = full_q;
		if (!enable) begin
			full_d = 1'b0;
		end else begin
			if (host_read) begin
				full_d = 1'b0;
			end
			// A new strobe beats a read in the same cycle.
			if (strobe_prev_q && !strobe_n) begin
				latched_d = pins;
				full_d    = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_prev_q <= 1'b1;
			latched_q     <= '0;
			full_q        <= 1'b0;
		end else begin
			strobe_prev_q <= strobe_prev_d;
			latched_q     <= latched_d;
			full_q        <= full_d;
		end
	end
endmodule // ppi_strobe_latch
`default_nettype wire

/* File: verification/ppi_port_asserts.sv */
`default_nettype none
module ppi_port_asserts (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic [1:0] addr,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata_q,
	input wire logic [7:0] port_a_out_q,
	input wire logic       port_a_oe_q,
	input wire logic       port_b_oe_q,
	input wire logic [7:0] port_c_oe_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] idle_q;
	wire  logic wr_go;
	wire  logic rd_go;
	// A held strobe acts once, so a take needs the strobe idle before.
	assign wr_go = !cs_n && !wr_n && idle_q[1];
	assign rd_go = !cs_n && !rd_n && idle_q[0];
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) idle_q <= 2'h3;
		else idle_q <= {wr_n || cs_n, rd_n || cs_n};
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_reset_idle;
		$rose(reset_n) |-> !port_a_oe_q && !port_b_oe_q
			&& port_c_oe_q == 8'h00 && rdata_q == 8'h00;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("port driven after reset");
	property p_no_set;
		wr_go && addr == 2'h3 && !wdata[7] |=>
			($stable(port_a_oe_q) && $stable(port_c_oe_q)) [*2];
	endproperty
	a_no_set: assert property (p_no_set)
		else $error("control word without set flag took effect");
	property p_dir_a;
		wr_go && addr == 2'h3 && wdata[7] |->
			##2 port_a_oe_q == !$past(wdata[4], 2);
	endproperty
	a_dir_a: assert property (p_dir_a)
		else $error("port A direction wrong");
	property p_dir_b;
		wr_go && addr == 2'h3 && wdata[7] |->
			##2 port_b_oe_q == !$past(wdata[1], 2);
	endproperty
	a_dir_b: assert property (p_dir_b)
		else $error("port B direction wrong");
	property p_dir_c;
		wr_go && addr == 2'h3 && wdata[7:5] == 3'h4 && !wdata[2] |->
			##2 port_c_oe_q == {{4{!$past(wdata[3], 2)}},
			{4{!$past(wdata[0], 2)}}};
	endproperty
	a_dir_c: assert property (p_dir_c)
		else $error("port C half direction wrong");
	property p_a_write;
		wr_go && addr == 2'h0 && port_a_oe_q |->
			##2 port_a_out_q == $past(wdata, 2);
	endproperty
	a_a_write: assert property (p_a_write)
		else $error("port A output not written");
	property p_rd_hold;
		$changed(rdata_q) |-> $past(rd_go) || $past(rd_go, 2);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	property p_out_hold;
		port_a_oe_q && $changed(port_a_out_q) |->
			$past(wr_go) || $past(wr_go, 2);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("port A output moved without a write");
	property p_oe_cause;
		$changed(port_b_oe_q) |-> $past(wr_go) || $past(wr_go, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("port B enable moved without a write");
	c_set: cover property (wr_go && addr == 2'h3 && wdata[7]);
	c_unset: cover property (wr_go && addr == 2'h3 && !wdata[7]);
	c_read: cover property (rd_go && addr == 2'h0);
endmodule // ppi_port_asserts
bind ppi_port ppi_port_asserts chk_u (.ref_clk, .reset_n, .addr, .cs_n,
	.rd_n, .wr_n, .wdata, .rdata_q, .port_a_out_q, .port_a_oe_q,
	.port_b_oe_q, .port_c_oe_q);
`default_nettype wire

/* File: verification/ppi_far_side.sv */
`default_nettype none
module ppi_far_side (
	input  wire logic [7:0] ext_a,
	input  wire logic [7:0] ext_b,
	input  wire logic [7:0] ext_c,
	input  wire logic [7:0] a_out,
	input  wire logic       a_oe,
	input  wire logic [7:0] b_out,
	input  wire logic       b_oe,
	input  wire logic [7:0] c_out,
	input  wire logic [7:0] c_oe,
	output var  logic [7:0] a_pin,
	output var  logic [7:0] b_pin,
	output var  logic [7:0] c_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released line shows the outside level, never the stale latch.
	always_comb begin
		a_pin = a_oe ? a_out : ext_a;
		b_pin = b_oe ? b_out : ext_b;
		c_pin = (c_out & c_oe) | (ext_c & ~c_oe);
	end
endmodule // ppi_far_side
`default_nettype wire

/* File: verification/programmable_parallel_io_port_test.sv */
`default_nettype none
module programmable_parallel_io_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] v;
		int         s;
	} note_t;
	logic       ref_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [1:0] addr = 2'h0;
	logic       cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, a_oe, b_oe;
	logic [7:0] wdata = 8'h00, ext_a = 8'h00, ext_b = 8'h00;
	logic [7:0] ext_c = 8'hFF, seed = 8'h16, v, rdata_q;
	logic [7:0] a_out, b_out, c_out, c_oe, a_pin, b_pin, c_pin;
	int         n_fail = 0, checks = 0;
	note_t      q[$];
	always #4 ref_clk = ~ref_clk;
	ppi_port dut_u (.ref_clk, .reset_n, .addr, .cs_n, .rd_n, .wr_n,
		.wdata, .rdata_q, .port_a_in(a_pin), .port_a_out_q(a_out),
		.port_a_oe_q(a_oe), .port_b_in(b_pin), .port_b_out_q(b_out),
		.port_b_oe_q(b_oe), .port_c_in(c_pin), .port_c_out_q(c_out),
		.port_c_oe_q(c_oe));
	ppi_far_side far_u (.ext_a, .ext_b, .ext_c, .a_out, .a_oe, .b_out,
		.b_oe, .c_out, .c_oe, .a_pin, .b_pin, .c_pin);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] val(input int s);
		case (s)
		0: return rdata_q;
		1: return a_out;
		2: return {7'h00, a_oe};
		3: return b_out;
		4: return {7'h00, b_oe};
		6: return c_oe;
		default: return c_out & c_oe;
		endcase
	endfunction
	task automatic note(input int s, input logic [7:0] e);
		q.push_back('{e, s});
	endtask
	// Strobe is held past the taking edge; results settle one edge on.
	task automatic acc(input logic w, input logic [1:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		cs_n <= 1'b0;
		addr <= a;
		wdata <= d;
		if (w) wr_n <= 1'b0;
		else rd_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge ref_clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(negedge ref_clk) begin
		note_t n;
		while (q.size() > 0) begin
			n = q.pop_front();
			checks++;
			if (val(n.s) !== n.v) begin
				n_fail++;
				$display("ERROR %0t: sel %0d got %h exp %h",
					$time, n.s, val(n.s), n.v);
			end
		end
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int s = 0; s < 7; s++) note(s, 8'h00);
		acc(0, 2'h3, 8'h00);
		note(0, 8'h9B);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			ext_a <= seed;
			ext_b <= ~seed;
			ext_c <= seed ^ 8'h5A;
			acc(0, i[1:0], 8'h00);
			note(0, i == 0 ? seed : i == 1 ? ~seed : seed ^ 8'h5A);
		end
		$display("reset and live input test done");
		acc(1, 2'h3, 8'h60);
		acc(0, 2'h3, 8'h00);
		note(0, 8'h9B);
		note(2, 8'h00);
		$display("unset control word test done");
		for (int i = 0; i < 16; i++) begin
			v = {3'h4, i[3], i[2], 1'b0, i[1], i[0]};
			acc(1, 2'h3, v);
			note(2, {7'h00, ~v[4]});
			note(4, {7'h00, ~v[1]});
			note(6, {{4{~v[3]}}, {4{~v[0]}}});
			acc(0, 2'h3, 8'h00);
			note(0, v);
			seed = lfsr(seed);
			acc(1, 2'h0, seed);
			acc(1, 2'h1, ~seed);
			acc(1, 2'h2, seed);
			note(1, seed);
			if (!v[1]) note(3, ~seed);
			note(7, seed & {{4{~v[3]}}, {4{~v[0]}}});
			acc(0, 2'h0, 8'h00);
			note(0, v[4] ? ext_a : seed);
		end
		$display("direction test done");
		ext_c <= 8'hFF;
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'h08 : 8'h01;
			acc(1, 2'h3, i ? 8'hD9 : 8'hB9);
			note(6, i ? 8'h36 : 8'h66);
			seed = lfsr(seed);
			ext_a <= seed;
			ext_c <= ~v;
			repeat (2) @(posedge ref_clk);
			ext_c <= 8'hFF;
			ext_a <= ~seed;
			note(7, i ? 8'h34 : 8'h46);
			acc(0, 2'h0, 8'h00);
			note(0, seed);
			note(7, i ? 8'h04 : 8'h40);
			acc(1, 2'h1, ~seed);
			note(3, ~seed);
			note(7, i ? 8'h02 : 8'h20);
			ext_c <= i ? 8'hFE : 8'hEF;
			repeat (2) @(posedge ref_clk);
			ext_c <= 8'hFF;
			note(7, i ? 8'h04 : 8'h40);
		end
		acc(1, 2'h3, 8'h9D);
		note(6, 8'h66);
		acc(1, 2'h3, 8'hF9);
		note(6, 8'h36);
		$display("strobed input test done");
		@(posedge ref_clk);
		end_of_test();
	end
endmodule // programmable_parallel_io_port_test
`default_nettype wire
